// *** src/ebm_pkg.sv ***
// ebm_pkg: constants and carrier types of the external bus chip select mapper.
// assumes one 250 MHz clock; configuration arrives as plain ports.
package ebm_pkg;

   localparam int          EBM_NUM_SEL      = 8;
   localparam int          EBM_NUM_LOW_SEL  = 4;
   localparam int          EBM_NUM_HIGH_SEL = 4;
   localparam int          EBM_EXT_AW       = 24;
   localparam int          EBM_DW           = 16;
   localparam int          EBM_BASE_W       = 12;
   localparam int          EBM_BASE_LSB     = 20;
   localparam int          EBM_SHARED_LSB   = 20;
   localparam int          EBM_SHARED_MSB   = 23;

   // abort vectors handed to the processor
   localparam logic [31:0] EBM_PREFETCH_ABORT_VEC = 32'h0000000c;
   localparam logic [31:0] EBM_DATA_ABORT_VEC     = 32'h00000010;

   // base compare masks over address bits 31..20, per page size
   localparam logic [11:0] EBM_MASK_1M  = 12'hfff;
   localparam logic [11:0] EBM_MASK_4M  = 12'hffc;
   localparam logic [11:0] EBM_MASK_16M = 12'hff0;
   localparam logic [11:0] EBM_MASK_64M = 12'hfc0;

   localparam logic [2:0]  EBM_ALE_RESET = 3'h0;
   localparam logic [2:0]  EBM_ALE_MAX   = 3'h4;
   localparam logic [7:0]  EBM_BYTE_LANE_MASK = 8'hff;

   typedef enum logic [1:0] {
      EBM_PAGE_1M,
      EBM_PAGE_4M,
      EBM_PAGE_16M,
      EBM_PAGE_64M
   } ebm_page_t;

   typedef enum logic {
      EBM_WIDTH_8,
      EBM_WIDTH_16
   } ebm_width_t;

   typedef enum logic {
      EBM_BYTE_WRITE,
      EBM_BYTE_SELECT
   } ebm_bat_t;

   typedef enum logic {
      EBM_READ_STANDARD,
      EBM_READ_EARLY
   } ebm_read_proto_t;

   // one select_config_register
   typedef struct packed {
      logic                    enable;
      logic [EBM_BASE_W-1:0]   base;
      ebm_page_t               page;
      ebm_width_t              bus_width_field;
      ebm_bat_t                byte_access_type_field;
   } ebm_sel_cfg_t;

   // memory_control_register
   typedef struct packed {
      logic [2:0]              ale;
      ebm_read_proto_t         read_proto;
   } ebm_mcr_t;

   // internal bus request
   typedef struct packed {
      logic                    valid;
      logic [31:0]             addr;
      logic                    write;
      logic                    half;
      logic                    prefetch;
      logic [EBM_DW-1:0]       wdata;
   } ebm_req_t;

   // decoder result
   typedef struct packed {
      logic [EBM_NUM_SEL-1:0]  hits;
      logic                    abort;
      logic [2:0]              owner;
   } ebm_dec_t;

endpackage : ebm_pkg

// *** src/ebm_select_decoder.sv ***
// ebm_select_decoder: compares an address with the eight select pages.
// assumes a stable address and configuration; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module ebm_select_decoder
   import ebm_pkg::*;
(
   input  wire logic [31:0]       i_addr,
   input  wire ebm_sel_cfg_t      i_cfg [EBM_NUM_SEL],
   input  wire logic [2:0]        i_ale,
   output ebm_dec_t               o_dec
);

   function automatic logic [EBM_BASE_W-1:0] page_mask(input ebm_page_t p);
      case (p)
         EBM_PAGE_1M:  page_mask = EBM_MASK_1M;
         EBM_PAGE_4M:  page_mask = EBM_MASK_4M;
         EBM_PAGE_16M: page_mask = EBM_MASK_16M;
         default:      page_mask = EBM_MASK_64M;
      endcase
   endfunction : page_mask

   always_comb begin
      logic [EBM_BASE_W-1:0] top;
      logic [EBM_BASE_W-1:0] m;
      logic                  avail;
      top   = i_addr[31:EBM_BASE_LSB];
      m     = '0;
      avail = 1'b0;
      o_dec = '0;
      for (int i = 0; i < EBM_NUM_SEL; i++) begin
         // RULE15 per-select page size
         m = page_mask(i_cfg[i].page);
         // RULE9 selects need freed pin
         avail = (i < EBM_NUM_LOW_SEL) ? 1'b1 : (int'(i_ale) > (i - EBM_NUM_LOW_SEL));
         // RULE18 base compare above page
         o_dec.hits[i] = i_cfg[i].enable && avail && ((top & m) == (i_cfg[i].base & m));
      end
      // RULE6 lowest number governs
      for (int i = EBM_NUM_SEL - 1; i >= 0; i--) begin
         if (o_dec.hits[i]) begin
            o_dec.owner = 3'(i);
         end
      end
      // RULE5 no page hit aborts
      o_dec.abort = (o_dec.hits == '0);
   end

endmodule : ebm_select_decoder
`default_nettype wire

// *** src/ebm_bus_mapper.sv ***
// ebm_bus_mapper: external bus interface, maps internal accesses onto eight selects.
// assumes synchronous pin inputs, config held stable while an access runs.
// Operation
// RULE1 - eight selects, 24-bit address, top four lines shared, 64M reach.
// RULE2 - each select configures the data bus as 8 or 16 bit.
// RULE3 - 8-bit uses lines 0..23 as address, 16-bit uses lines 1..23.
// RULE4 - small devices simply repeat inside their page; accesses still complete.
// RULE5 - unmapped access raises prefetch or data abort with fixed vectors.
// RULE6 - shared base asserts both selects; lower number sets the access behaviour.
// RULE7 - selects 0..3 are active-low pins, 4..7 active-high on top address lines.
// RULE8 - line setting swaps 0..4 top lines for selects, from line 23 down.
// RULE9 - reach per device is 16M with four devices, 1M with eight.
// RULE10 - 16-bit selects choose byte-write or byte-select control signalling.
// RULE11 - byte-write: line 0 unused, two write strobes, one read strobe.
// RULE12 - byte-select: two byte enables, one write strobe, one output enable.
// RULE13 - pins pair up: a0/lower enable, read/output enable, writes/upper enable.
// RULE14 - a zero-wait access completes in one clock cycle; a standard read here takes two per beat, setup then strobe.
// RULE15 - each select has its own base and page size configuration.
// RULE16 - standard read protocol after reset until software picks early read.
// RULE17 - wait request low freezes outputs and state until released.
// RULE18 - select decoded from bits above page; offset presented on address lines.
`timescale 1ns/1ps
`default_nettype none
module ebm_bus_mapper
   import ebm_pkg::*;
(
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_rst_n,
   input  wire ebm_sel_cfg_t                i_select_config_register [EBM_NUM_SEL],
   input  wire ebm_mcr_t                    i_memory_control_register,
   input  wire ebm_req_t                    i_req,
   output logic                             o_ready,
   output logic                             o_ack,
   output logic [EBM_DW-1:0]                o_rdata,
   output logic                             o_prefetch_abort,
   output logic                             o_data_abort,
   output logic [31:0]                      o_abort_vector,
   output logic [EBM_EXT_AW-1:0]            o_addr_pins,
   output logic [EBM_NUM_LOW_SEL-1:0]       o_low_true_selects_0_3_n,
   output logic                             o_read_strobe_n,
   output logic                             o_low_byte_write_strobe_n,
   output logic                             o_high_byte_write_strobe_n,
   output logic [EBM_DW-1:0]                o_data_out,
   output logic                             o_data_oe,
   input  wire logic [EBM_DW-1:0]           i_data_in,
   input  wire logic                        i_wait_request_n
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE
   } ebm_state_t;

   ebm_state_t                 state;
   ebm_dec_t                   dec;
   ebm_req_t                   cur;
   ebm_sel_cfg_t               own_cfg;
   logic [EBM_NUM_SEL-1:0]     cur_hits;
   logic                       second_beat;
   logic                       beat_hi;
   logic [2:0]                 ale_eff;
   logic                       frozen;
   logic                       take;

   ebm_select_decoder u_dec (
      .i_addr (i_req.addr),
      .i_cfg  (i_select_config_register),
      .i_ale  (ale_eff),
      .o_dec  (dec)
   );

   // RULE8 clamp line setting
   assign ale_eff = (i_memory_control_register.ale > EBM_ALE_MAX) ? EBM_ALE_MAX
                                                                  : i_memory_control_register.ale;
   // RULE17 freeze on wait
   assign frozen  = (state != ST_IDLE) && !i_wait_request_n;
   assign take    = (state == ST_IDLE) && i_req.valid;

   // RULE1 24-bit shared pins
   // builds the shared address pins: offset below, selects 4..7 from line 23 down
   function automatic logic [EBM_EXT_AW-1:0] pin_addr(input logic [31:0] a,
                                                     input logic [EBM_NUM_SEL-1:0] hits,
                                                     input logic [2:0] ale,
                                                     input ebm_sel_cfg_t c,
                                                     input logic half,
                                                     input logic hi_beat);
      logic [EBM_EXT_AW-1:0] p;
      p = a[EBM_EXT_AW-1:0];
      // RULE3 byte address on 8-bit
      if (c.bus_width_field == EBM_WIDTH_8 && half) begin
         p[0] = hi_beat;
      end
      if (c.bus_width_field == EBM_WIDTH_16) begin
         // RULE13 a0 doubles as lower enable
         if (c.byte_access_type_field == EBM_BYTE_SELECT) begin
            p[0] = !(half || !a[0]);
         end else begin
            // RULE11 line 0 unused
            p[0] = 1'b1;
         end
      end
      for (int k = 0; k < EBM_NUM_HIGH_SEL; k++) begin
         // RULE7 active-high shared selects
         if (int'(ale) > k) begin
            p[EBM_SHARED_MSB-k] = hits[EBM_NUM_LOW_SEL+k];
         end
      end
      pin_addr = p;
   endfunction : pin_addr

   // state and beat tracking
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state       <= ST_IDLE;
         cur         <= '0;
         cur_hits    <= '0;
         own_cfg     <= '0;
         second_beat <= 1'b0;
         beat_hi     <= 1'b0;
      end else if (!frozen) begin
         case (state)
            ST_IDLE: begin
               if (take && !dec.abort) begin
                  cur      <= i_req;
                  cur_hits <= dec.hits;
                  // RULE6 owner config latched
                  own_cfg  <= i_select_config_register[dec.owner];
                  beat_hi  <= 1'b0;
                  second_beat <= (i_select_config_register[dec.owner].bus_width_field == EBM_WIDTH_8)
                                 && i_req.half;
                  // RULE16 standard read adds setup
                  if (!i_req.write && i_memory_control_register.read_proto == EBM_READ_STANDARD) begin
                     state <= ST_SETUP;
                  end else begin
                     // RULE14 single cycle access
                     state <= ST_STROBE;
                  end
               end
            end
            ST_SETUP: begin
               state <= ST_STROBE;
            end
            ST_STROBE: begin
               if (second_beat) begin
                  second_beat <= 1'b0;
                  beat_hi     <= 1'b1;
                  state       <= (!cur.write && i_memory_control_register.read_proto == EBM_READ_STANDARD)
                                 ? ST_SETUP : ST_STROBE;
               end else begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // pin drive, registered for the coming cycle
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      logic [EBM_NUM_SEL-1:0] h;
      logic                   strobe;
      logic                   lo_b;
      logic                   hi_b;
      if (!i_rst_n) begin
         o_addr_pins                <= '0;
         o_low_true_selects_0_3_n   <= '1;
         o_read_strobe_n            <= 1'b1;
         o_low_byte_write_strobe_n  <= 1'b1;
         o_high_byte_write_strobe_n <= 1'b1;
         o_data_out                 <= '0;
         o_data_oe                  <= 1'b0;
      end else if (!frozen) begin
         h      = '0;
         strobe = 1'b0;
         lo_b   = 1'b0;
         hi_b   = 1'b0;
         if (take && !dec.abort) begin
            h      = dec.hits;
            strobe = i_req.write || (i_memory_control_register.read_proto == EBM_READ_EARLY);
            // RULE2 width per select
            if (i_select_config_register[dec.owner].bus_width_field == EBM_WIDTH_16) begin
               lo_b = i_req.half || !i_req.addr[0];
               hi_b = i_req.half || i_req.addr[0];
            end else begin
               lo_b = 1'b1;
            end
            // RULE18 offset on address lines
            o_addr_pins <= pin_addr(i_req.addr, dec.hits, ale_eff, i_select_config_register[dec.owner],
                                    i_req.half, 1'b0);
            o_data_out  <= (i_select_config_register[dec.owner].bus_width_field == EBM_WIDTH_16
                            && !i_req.half)
                           ? {2{i_req.wdata[7:0]}} : i_req.wdata;
            o_data_oe   <= i_req.write;
            // RULE4 page wrap is inherent
            own_drive(i_req.write, strobe, lo_b, hi_b, i_select_config_register[dec.owner]);
         end else if ((state == ST_SETUP) || (state == ST_STROBE && second_beat)) begin
            h      = cur_hits;
            strobe = (state == ST_SETUP) || cur.write
                     || (i_memory_control_register.read_proto == EBM_READ_EARLY);
            lo_b   = 1'b1;
            o_addr_pins <= pin_addr(cur.addr, cur_hits, ale_eff, own_cfg, cur.half,
                                    beat_hi || (state == ST_STROBE));
            o_data_out  <= (state == ST_STROBE) ? {8'h00, cur.wdata[15:8]} : o_data_out;
            own_drive(cur.write, strobe, own_cfg.bus_width_field == EBM_WIDTH_16 ? cur.half || !cur.addr[0]
                      : lo_b, own_cfg.bus_width_field == EBM_WIDTH_16 && (cur.half || cur.addr[0]), own_cfg);
         end else begin
            own_drive(1'b0, 1'b0, 1'b0, 1'b0, own_cfg);
            o_data_oe <= 1'b0;
         end
         // RULE6 all hits asserted
         o_low_true_selects_0_3_n <= ~h[EBM_NUM_LOW_SEL-1:0];
      end
   end

   // control strobe mapping by width and byte access type
   task automatic own_drive(input logic wr, input logic strobe, input logic lo_b, input logic hi_b,
                            input ebm_sel_cfg_t c);
      if (c.bus_width_field == EBM_WIDTH_16 && c.byte_access_type_field == EBM_BYTE_SELECT) begin
         // RULE12 enables plus single strobes
         o_read_strobe_n            <= !(strobe && !wr);
         o_low_byte_write_strobe_n  <= !(strobe && wr);
         // RULE13 upper enable on high pin
         o_high_byte_write_strobe_n <= !(strobe && hi_b);
      end else begin
         // RULE10 byte-write signalling
         // RULE11 per-byte write strobes
         o_read_strobe_n            <= !(strobe && !wr);
         o_low_byte_write_strobe_n  <= !(strobe && wr && lo_b);
         o_high_byte_write_strobe_n <= !(strobe && wr && hi_b);
      end
   endtask : own_drive

   // request handshake, read data and abort reporting
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ready          <= 1'b1;
         o_ack            <= 1'b0;
         o_rdata          <= '0;
         o_prefetch_abort <= 1'b0;
         o_data_abort     <= 1'b0;
         o_abort_vector   <= '0;
      end else begin
         o_ack            <= 1'b0;
         o_prefetch_abort <= 1'b0;
         o_data_abort     <= 1'b0;
         if (take && dec.abort) begin
            // RULE5 abort kind and vector
            o_prefetch_abort <= i_req.prefetch;
            o_data_abort     <= !i_req.prefetch;
            o_abort_vector   <= i_req.prefetch ? EBM_PREFETCH_ABORT_VEC : EBM_DATA_ABORT_VEC;
         end
         if (take && !dec.abort) begin
            o_ready <= 1'b0;
         end
         if (state == ST_STROBE && !frozen) begin
            if (!cur.write) begin
               if (own_cfg.bus_width_field == EBM_WIDTH_8) begin
                  if (beat_hi) begin
                     o_rdata[15:8] <= i_data_in[7:0];
                  end else begin
                     o_rdata <= {8'h00, i_data_in[7:0]};
                  end
               end else if (!cur.half && cur.addr[0]) begin
                  o_rdata <= {8'h00, i_data_in[15:8]};
               end else begin
                  o_rdata <= i_data_in & {EBM_BYTE_LANE_MASK, EBM_BYTE_LANE_MASK};
               end
            end
            if (!second_beat) begin
               o_ack   <= 1'b1;
               o_ready <= 1'b1;
            end
         end
      end
   end

endmodule : ebm_bus_mapper
`default_nettype wire

// *** tb/ebm_properties.sv ***
// ebm_properties: port assertions for the external bus mapper.
// assumes bind onto ebm_bus_mapper, single clock domain.
`timescale 1ns/1ps
`default_nettype none
module ebm_properties
   import ebm_pkg::*;
(
   input wire logic                       i_ref_clk,
   input wire logic                       i_rst_n,
   input wire ebm_mcr_t                   i_memory_control_register,
   input wire ebm_req_t                   i_req,
   input wire logic                       i_wait_request_n,
   input wire logic                       o_ready,
   input wire logic                       o_ack,
   input wire logic                       o_prefetch_abort,
   input wire logic                       o_data_abort,
   input wire logic [31:0]                o_abort_vector,
   input wire logic [EBM_NUM_LOW_SEL-1:0] o_low_true_selects_0_3_n,
   input wire logic                       o_read_strobe_n,
   input wire logic                       o_low_byte_write_strobe_n,
   input wire logic                       o_high_byte_write_strobe_n,
   input wire logic                       o_data_oe
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   logic taken;
   logic [7:0] pins;
   assign taken = o_ready && i_req.valid;
   assign pins = {o_low_true_selects_0_3_n, o_read_strobe_n, o_low_byte_write_strobe_n,
                  o_high_byte_write_strobe_n, o_data_oe};

   ack_single_pulse_a: assert property (o_ack |=> !o_ack)
      else $error("ack held longer than one cycle");
   abort_exclusive_a: assert property (!(o_prefetch_abort && o_data_abort))
      else $error("both abort kinds at once");
   data_vector_a: assert property (o_data_abort |->
      o_abort_vector == EBM_DATA_ABORT_VEC && $past(taken && !i_req.prefetch))
      else $error("data abort vector or cause wrong");
   fetch_vector_a: assert property (o_prefetch_abort |->
      o_abort_vector == EBM_PREFETCH_ABORT_VEC && $past(taken && i_req.prefetch))
      else $error("prefetch abort vector or cause wrong");
   wait_freeze_a: assert property ((!i_wait_request_n && !o_ready && !o_data_abort
      && !o_prefetch_abort) |=> $stable(pins) && !o_ack)
      else $error("outputs moved during wait");
   select_on_strobe_a: assert property ((i_memory_control_register.ale == 3'h0 &&
      !(o_read_strobe_n && o_low_byte_write_strobe_n)) |-> o_low_true_selects_0_3_n != 4'hf)
      else $error("strobe without select");
   idle_strobes_a: assert property ((o_ready && !o_ack) |->
      o_read_strobe_n && o_low_byte_write_strobe_n && o_high_byte_write_strobe_n && !o_data_oe)
      else $error("strobe active while idle");
   drive_on_write_a: assert property (o_data_oe |-> o_read_strobe_n &&
      !(o_low_byte_write_strobe_n && o_high_byte_write_strobe_n))
      else $error("data driven outside a write");
   access_ends_a: assert property (taken |=> ##[0:24] (o_ack || o_prefetch_abort || o_data_abort))
      else $error("access never finished");

   cover property (taken && i_req.write);
   cover property (o_data_abort);
   cover property (!i_wait_request_n && !o_ready);
endmodule : ebm_properties

bind ebm_bus_mapper ebm_properties ebm_properties_i (
   .i_ref_clk, .i_rst_n, .i_memory_control_register, .i_req, .i_wait_request_n, .o_ready,
   .o_ack, .o_prefetch_abort, .o_data_abort, .o_abort_vector, .o_low_true_selects_0_3_n,
   .o_read_strobe_n, .o_low_byte_write_strobe_n, .o_high_byte_write_strobe_n, .o_data_oe
);
`default_nettype wire

// *** tb/ebm_ext_mem.sv ***
// ebm_ext_mem: behavioural external memory on one select.
// assumes strobes sampled on the edge ending their cycle.
`timescale 1ns/1ps
`default_nettype none
module ebm_ext_mem
   import ebm_pkg::*;
#(
   parameter int MODE = 0 // 0 8-bit, 1 byte write pair, 2 byte select
)(
   input wire logic                  i_clk,
   input wire logic                  i_sel_n,
   input wire logic [EBM_EXT_AW-1:0] i_addr,
   input wire logic                  i_rd_n,
   input wire logic                  i_wr0_n,
   input wire logic                  i_wr1_n,
   input wire logic [EBM_DW-1:0]     i_wdata,
   output logic [EBM_DW-1:0]         o_rdata,
   output logic                      o_drive
);
   logic [EBM_DW-1:0] mem [256];
   logic [7:0]        idx;
   logic [7:0]        bsel;
   logic              lo_we;
   logic              hi_we;
   assign idx = i_addr[8:1];
   assign lo_we = !i_wr0_n && (MODE == 1 || !i_addr[0]);
   assign hi_we = MODE == 0 ? !i_wr0_n && i_addr[0] : MODE == 1 ? !i_wr1_n : !i_wr0_n && !i_wr1_n;
   always_ff @(posedge i_clk) begin
      if (!i_sel_n && lo_we)
         mem[idx][7:0] <= i_wdata[7:0];
      if (!i_sel_n && hi_we)
         mem[idx][15:8] <= MODE == 0 ? i_wdata[7:0] : i_wdata[15:8];
   end
   // 8-bit part drives the inverse of its byte on the upper lines
   assign bsel = i_addr[0] ? mem[idx][15:8] : mem[idx][7:0];
   assign o_rdata = MODE == 0 ? {~bsel, bsel} : mem[idx];
   assign o_drive = !i_sel_n && !i_rd_n;
endmodule : ebm_ext_mem
`default_nettype wire

// *** tb/tb.sv ***
// tb: self-checking bench for ebm_bus_mapper with three memories.
// assumes nothing outside; makes clock, reset and pin traffic.
`timescale 1ns/1ps
`default_nettype none
module tb
   import ebm_pkg::*;
;
   typedef struct packed {
      logic [31:0] a;
      logic        w, h, pf;
      logic [15:0] d;
      logic [3:0]  lat;
      logic [1:0]  ab;
   } ebm_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   ebm_sel_cfg_t cfg [EBM_NUM_SEL];
   ebm_mcr_t mcr;
   ebm_req_t req;
   logic wait_n, ready, ack, pab, dab, oe, rd_n, wr0_n, wr1_n;
   logic [31:0] vec;
   logic [23:0] apins, s_ap;
   logic [3:0] sel_n, s_sel;
   logic [3:0] s_st;
   logic [15:0] rdata, dout, din, d0, d1, d2, dlast, s_do;
   logic [2:0] drv;
   int errors = 0;
   int check_count = 0;
   int lat;
   ebm_row_t rows [16] = '{
      '{32'h01000012, 1'b1, 1'b1, 1'b0, 16'h1234, 4'h1, 2'h0},
      '{32'h01000012, 1'b0, 1'b1, 1'b0, 16'h1234, 4'h2, 2'h0},
      '{32'h01000013, 1'b1, 1'b0, 1'b0, 16'h00ab, 4'h1, 2'h0},
      '{32'h01000012, 1'b0, 1'b1, 1'b0, 16'hab34, 4'h2, 2'h0},
      '{32'h01000212, 1'b0, 1'b1, 1'b0, 16'hab34, 4'h2, 2'h0},
      '{32'h01000013, 1'b0, 1'b0, 1'b0, 16'h00ab, 4'h2, 2'h0},
      '{32'h02000020, 1'b1, 1'b1, 1'b0, 16'hc3d4, 4'h2, 2'h0},
      '{32'h02000020, 1'b0, 1'b1, 1'b0, 16'hc3d4, 4'h4, 2'h0},
      '{32'h02000021, 1'b0, 1'b0, 1'b0, 16'h00c3, 4'h2, 2'h0},
      '{32'h03000040, 1'b1, 1'b1, 1'b0, 16'h5e6f, 4'h1, 2'h0},
      '{32'h03000040, 1'b1, 1'b0, 1'b0, 16'h0011, 4'h1, 2'h0},
      '{32'h03000040, 1'b0, 1'b1, 1'b0, 16'h5e11, 4'h2, 2'h0},
      '{32'h03000041, 1'b0, 1'b0, 1'b0, 16'h005e, 4'h2, 2'h0},
      '{32'h05000000, 1'b0, 1'b1, 1'b0, 16'h0000, 4'h0, 2'h1},
      '{32'h05000000, 1'b0, 1'b1, 1'b1, 16'h0000, 4'h0, 2'h2},
      '{32'h04000000, 1'b1, 1'b1, 1'b0, 16'h0000, 4'h0, 2'h1}};

   always #2 clk = ~clk;
   // released data lines show the inverse of the last value
   assign din = oe ? dout : drv[0] ? d0 : drv[1] ? d1 : drv[2] ? d2 : ~dlast;
   always_ff @(posedge clk) dlast <= din;

   ebm_bus_mapper ebm_bus_mapper_i (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_select_config_register(cfg),
      .i_memory_control_register(mcr), .i_req(req), .o_ready(ready), .o_ack(ack),
      .o_rdata(rdata), .o_prefetch_abort(pab), .o_data_abort(dab), .o_abort_vector(vec),
      .o_addr_pins(apins), .o_low_true_selects_0_3_n(sel_n), .o_read_strobe_n(rd_n),
      .o_low_byte_write_strobe_n(wr0_n), .o_high_byte_write_strobe_n(wr1_n),
      .o_data_out(dout), .o_data_oe(oe), .i_data_in(din), .i_wait_request_n(wait_n));
   ebm_ext_mem #(.MODE(2)) ebm_ext_mem_i0 (.i_clk(clk), .i_sel_n(sel_n[0]), .i_addr(apins),
      .i_rd_n(rd_n), .i_wr0_n(wr0_n), .i_wr1_n(wr1_n), .i_wdata(dout), .o_rdata(d0), .o_drive(drv[0]));
   ebm_ext_mem #(.MODE(0)) ebm_ext_mem_i1 (.i_clk(clk), .i_sel_n(sel_n[1]), .i_addr(apins),
      .i_rd_n(rd_n), .i_wr0_n(wr0_n), .i_wr1_n(wr1_n), .i_wdata(dout), .o_rdata(d1), .o_drive(drv[1]));
   ebm_ext_mem #(.MODE(1)) ebm_ext_mem_i2 (.i_clk(clk), .i_sel_n(sel_n[2]), .i_addr(apins),
      .i_rd_n(rd_n), .i_wr0_n(wr0_n), .i_wr1_n(wr1_n), .i_wdata(dout), .o_rdata(d2), .o_drive(drv[2]));

   function automatic ebm_sel_cfg_t mk(input logic [11:0] b, input ebm_width_t w, input ebm_bat_t t);
      return '{1'b1, b, EBM_PAGE_1M, w, t};
   endfunction : mk

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim

   // one access; snapshot of the pins in its first cycle, stall for st cycles
   task automatic acc(input logic [31:0] a, input logic w, input logic h, input logic pf,
                      input logic [15:0] d, input int st);
      @(posedge clk);
      req <= '{1'b1, a, w, h, pf, d};
      @(posedge clk);
      req.valid <= 1'b0;
      wait_n <= (st == 0);
      lat = 0;
      #1;
      s_sel = sel_n;
      s_ap = apins;
      s_st = {rd_n, wr0_n, wr1_n, oe};
      s_do = dout;
      while (!(ack || pab || dab) && lat < 40) begin
         @(posedge clk);
         lat++;
         wait_n <= (lat >= st);
         #1;
      end
   endtask : acc

   initial begin
      foreach (cfg[k]) cfg[k] = '0;
      cfg[0] = mk(12'h010, EBM_WIDTH_16, EBM_BYTE_SELECT);
      cfg[1] = mk(12'h020, EBM_WIDTH_8, EBM_BYTE_WRITE);
      cfg[2] = mk(12'h030, EBM_WIDTH_16, EBM_BYTE_WRITE);
      cfg[3] = mk(12'h010, EBM_WIDTH_8, EBM_BYTE_WRITE);
      cfg[4] = mk(12'h040, EBM_WIDTH_16, EBM_BYTE_SELECT);
      mcr = '{EBM_ALE_RESET, EBM_READ_STANDARD};
      req = '0;
      wait_n = 1'b1;
      repeat (20) @(posedge clk);
      chk({ready, sel_n, rd_n, wr0_n, wr1_n, oe, pab, dab, ack}, 12'hff0);
      rst_n <= 1'b1;
      $display("reset done");
      foreach (rows[k]) begin
         acc(rows[k].a, rows[k].w, rows[k].h, rows[k].pf, rows[k].d, 0);
         chk(32'(lat), rows[k].lat);
         chk({pab, dab}, rows[k].ab);
         if (rows[k].ab != 2'h0)
            chk(vec, rows[k].pf ? EBM_PREFETCH_ABORT_VEC : EBM_DATA_ABORT_VEC);
         else if (!rows[k].w)
            chk(rows[k].h ? rdata : {8'h00, rdata[7:0]}, rows[k].d);
      end
      $display("rows done");
      acc(32'h01000020, 1'b1, 1'b0, 1'b0, 16'h00cd, 0);
      chk(s_sel, 4'h6);
      chk(s_ap[19:0], 20'h00020);
      chk({s_st, s_do[7:0]}, 12'hbcd);
      acc(32'h03000051, 1'b1, 1'b0, 1'b0, 16'h0077, 0);
      chk({s_sel, s_ap[0]}, 5'h17);
      chk({s_st, s_do[15:8]}, 12'hd77);
      $display("pins done");
      acc(32'h01000030, 1'b1, 1'b1, 1'b0, 16'h9abc, 3);
      chk(32'(lat), 32'h4);
      acc(32'h01000030, 1'b0, 1'b1, 1'b0, 16'h0000, 0);
      chk({rdata, 8'(lat)}, 24'h9abc02);
      @(posedge clk);
      mcr.read_proto <= EBM_READ_EARLY;
      acc(32'h01000030, 1'b0, 1'b1, 1'b0, 16'h0000, 0);
      chk({rdata, 8'(lat)}, 24'h9abc01);
      $display("wait and protocol done");
      for (int k = 1; k < 5; k++) begin
         @(posedge clk);
         mcr.ale <= 3'(k);
         acc(32'h04000022, 1'b1, 1'b1, 1'b0, 16'h4455, 0);
         chk({s_ap[23:20], s_sel, 8'(lat)}, 16'h8f01);
      end
      cfg[5] <= '{1'b1, 12'h0c0, EBM_PAGE_64M, EBM_WIDTH_16, EBM_BYTE_SELECT};
      acc(32'h0ff00010, 1'b1, 1'b1, 1'b0, 16'h0101, 0);
      chk({s_ap[23:20], s_sel}, 8'h4f);
      $display("line sharing done");
      end_sim();
   end

   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      end_sim();
   end
endmodule : tb
`default_nettype wire
